// ==== verilog/ser_global_cfg.sv ====
// Purpose: Global configuration registers: target address, reset commands, lane setup.
// Assumes: Register port driven by the I2C target logic on sys_clk; straps are pins.
// Notes:   Summary of operation follows.
// Summary of operation
// - Address field always shows address in use.
// - Address writable only while override set.
// - Override bit selects strap or programmed address.
// - Bit two launches ROM reload, self-clears.
// - Bit one resets logic and registers.
// - Bit zero resets logic, keeps registers.
// - Strap fields load from sampled strap pins.
// - Bit six selects continuous clock lane.
// - Bits five-four select lane count, default four.
// - Bit one enables transmit CRC, default on.
// - Bit zero shows strapped I2C level, writable.
`timescale 1ns/1ps
module ser_global_cfg
  import ser_cfg_pkg::*;
#(
  parameter int PULSE_LEN = ser_cfg_pkg::PULSE_CYC
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Strap pins, asynchronous
  input  wire logic [6:0]           strap_address,
  input  wire logic                 address_strap_pin,
  // Register port from the I2C target
  input  wire ser_cfg_pkg::reg_req_t req,
  output ser_cfg_pkg::cfg_out_t     cfg,
  output logic [7:0]                rdata,
  output logic                      rdata_valid,
  // Commands to the rest of the device
  output logic                      rom_reload_cmd,
  output logic                      logic_reset_out,
  output logic                      strap_done
);
  import ser_cfg_pkg::*;

  // Strap synchronisers; first stage read only by the second.
  logic [7:0] strap_s1_ff;
  logic [7:0] strap_s2_ff;
  logic       strap_done_ff;
  // Register state.
  logic [6:0] addr_prog_ff;
  logic [6:0] addr_strap_ff;
  logic       level_strap_ff;
  logic       override_ff;
  logic [4:0] rst_rsvd_ff;
  logic       gen_rsvd7_ff;
  logic [1:0] gen_rsvd32_ff;
  logic       cont_ff;
  logic [1:0] lane_ff;
  logic       crc_ff;
  logic       level_ff;
  logic       reg_reset_ff;
  logic       pulse_reload;
  logic       pulse_rst1;
  logic       pulse_rst0;

  // Offset decodes are shared by the write strobes and the read selector.
  wire        hit_id    = (req.addr == ADDR_ID);
  wire        hit_rst   = (req.addr == ADDR_RST);
  wire        hit_gen   = (req.addr == ADDR_GEN);

  wire        reg_rst   = rst || reg_reset_ff;
  wire        wr_id     = req.wr && hit_id;
  wire        wr_rst    = req.wr && hit_rst;
  wire        wr_gen    = req.wr && hit_gen;
  wire        go_reload = wr_rst && req.wdata[RELOAD_BIT];
  wire        go_rst1   = wr_rst && req.wdata[RST1_BIT];
  wire        go_rst0   = wr_rst && req.wdata[RST0_BIT];
  wire [6:0]  addr_used = override_ff ? addr_prog_ff : addr_strap_ff;
  wire [7:0]  id_word   = {addr_used, override_ff};
  // Command bits read back as one only while their pulse runs, then as zero.
  wire [7:0]  rst_word  = {rst_rsvd_ff, pulse_reload, pulse_rst1, pulse_rst0};
  wire [7:0]  gen_word  = {gen_rsvd7_ff, cont_ff, lane_ff, gen_rsvd32_ff, crc_ff, level_ff};
  wire [7:0]  rd_mux    = hit_id  ? id_word  :
                          hit_rst ? rst_word :
                          hit_gen ? gen_word : 8'h00;

  // Straps sampled through two flops, captured once after reset release.
  always_ff @(posedge sys_clk) begin
    strap_s1_ff <= {address_strap_pin, strap_address};
    strap_s2_ff <= strap_s1_ff;
  end

  // The latched straps are the defaults of the strap-set fields.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strap_done_ff  <= 1'b0;
      addr_strap_ff  <= 7'h00;
      level_strap_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff  <= 1'b1;
      addr_strap_ff  <= strap_s2_ff[6:0];
      level_strap_ff <= strap_s2_ff[7];
    end
  end

  // Register-file reset by bit one is held one cycle in a flop to avoid a loop.
  // Bit zero needs no local action: only the outgoing pulse resets the logic.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_reset_ff <= 1'b0;
    end else begin
      reg_reset_ff <= go_rst1;
    end
  end

  // The address field follows the override bit as it stood before the write, so
  // setting override and a new address takes two writes; with override clear the
  // programmed copy tracks the strap, so setting override keeps the address steady.
  always_ff @(posedge sys_clk) begin
    if (reg_rst) begin
      override_ff  <= OVR_RST;
      addr_prog_ff <= 7'h00;
    end else if (wr_id) begin
      override_ff <= req.wdata[OVR_BIT];
      if (override_ff) begin
        addr_prog_ff <= req.wdata[7:ID_LSB];
      end else begin
        addr_prog_ff <= addr_strap_ff;
      end
    end else if (!override_ff) begin
      addr_prog_ff <= addr_strap_ff;
    end
  end

  // Reserved bits are plain storage and read back what was last written.
  always_ff @(posedge sys_clk) begin
    if (reg_rst) begin
      rst_rsvd_ff <= RST_RSVD_RST;
    end else if (wr_rst) begin
      rst_rsvd_ff <= req.wdata[7:3];
    end
  end

  // Level bit reloads from strap when captured; later writes override it.
  // A register wipe returns it to the latched strap rather than a fixed zero,
  // since its default is the strap; the pins themselves are not sampled again.
  // Nothing stops a local host from writing it; keeping such writes on the
  // back channel is left to the host side.
  always_ff @(posedge sys_clk) begin
    if (reg_rst) begin
      gen_rsvd7_ff  <= 1'b0;
      cont_ff       <= CONT_RST;
      lane_ff       <= LANE_RST;
      gen_rsvd32_ff <= 2'h0;
      crc_ff        <= CRC_RST;
      level_ff      <= level_strap_ff;
    end else if (wr_gen) begin
      gen_rsvd7_ff  <= req.wdata[7];
      cont_ff       <= req.wdata[CONT_BIT];
      lane_ff       <= req.wdata[LANE_LSB +: 2];
      gen_rsvd32_ff <= req.wdata[3:2];
      crc_ff        <= req.wdata[CRC_BIT];
      level_ff      <= req.wdata[VSEL_BIT];
    end else if (!strap_done_ff) begin
      level_ff <= strap_s2_ff[7];
    end
  end

  // No read-to-clear or latched fields exist in these three registers.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      rdata       <= req.rd ? rd_mux : rdata;
      rdata_valid <= req.rd;
    end
  end

  // Every field leaves through a flop, so downstream sees a write one cycle late.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg        <= '0;
      strap_done <= 1'b0;
    end else begin
      cfg.clock_lane_continuous_sel <= cont_ff;
      cfg.lane_sel                  <= lane_ff;
      cfg.crc_tx_enable             <= crc_ff;
      cfg.i2c_level_sel             <= level_ff;
      cfg.own_target_address        <= addr_used;
      strap_done                    <= strap_done_ff;
    end
  end

  // Both digital resets leave on one line; the register wipe of bit one is local.
  // A command arriving while its own pulse runs is dropped, not queued.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rom_reload_cmd  <= 1'b0;
      logic_reset_out <= 1'b0;
    end else begin
      rom_reload_cmd  <= pulse_reload;
      logic_reset_out <= pulse_rst1 || pulse_rst0;
    end
  end

  // One stretcher per command bit.
  cmd_pulse #(.LEN(PULSE_LEN)) u_reload (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (go_reload),
    .pulse   (pulse_reload)
  );
  cmd_pulse #(.LEN(PULSE_LEN)) u_rst1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (go_rst1),
    .pulse   (pulse_rst1)
  );
  cmd_pulse #(.LEN(PULSE_LEN)) u_rst0 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (go_rst0),
    .pulse   (pulse_rst0)
  );
endmodule : ser_global_cfg

// ==== verilog/ser_cfg_pkg.sv ====
// Purpose: Shared constants and types for the serializer global configuration registers.
// Assumes: 8-bit register port with byte-wide addresses, one clock.
// Notes:   Offsets and fields follow the register map of the block.
package ser_cfg_pkg;
  localparam logic [7:0] ADDR_ID      = 8'h00;
  localparam logic [7:0] ADDR_RST     = 8'h01;
  localparam logic [7:0] ADDR_GEN     = 8'h02;
  localparam int         ID_LSB       = 1;
  localparam int         OVR_BIT      = 0;
  localparam int         RELOAD_BIT   = 2;
  localparam int         RST1_BIT     = 1;
  localparam int         RST0_BIT     = 0;
  localparam int         CONT_BIT     = 6;
  localparam int         LANE_LSB     = 4;
  localparam int         CRC_BIT      = 1;
  localparam int         VSEL_BIT     = 0;
  localparam logic [4:0] RST_RSVD_RST = 5'h00;
  localparam logic [1:0] LANE_RST     = 2'h3;
  localparam logic       CRC_RST      = 1'b1;
  localparam logic       CONT_RST     = 1'b0;
  localparam logic       OVR_RST      = 1'b0;
  localparam int         PULSE_CYC    = 2;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       clock_lane_continuous_sel;
    logic [1:0] lane_sel;
    logic       crc_tx_enable;
    logic       i2c_level_sel;
    logic [6:0] own_target_address;
  } cfg_out_t;
endpackage : ser_cfg_pkg

// ==== verilog/cmd_pulse.sv ====
// Purpose: Stretches a one-cycle command into a fixed-length pulse.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   Busy is high while the pulse runs, so the command bit reads back as one.
`timescale 1ns/1ps
module cmd_pulse #(
  parameter int LEN = 2
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Command
  input  wire logic start,
  output logic      pulse
);
  logic [7:0] cnt_ff;
  wire        busy = (cnt_ff != 8'h00);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff <= 8'h00;
    end else if (start && !busy) begin
      cnt_ff <= 8'(LEN);
    end else if (busy) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= (start && !busy) || (cnt_ff > 8'h01);
    end
  end
endmodule : cmd_pulse

// ==== dv/ser_cfg_chk.sv ====
// Purpose: Port checks of the global configuration registers.
// Assumes: One clock, synchronous reset.
// Notes:   Bound into every register block.
`timescale 1ns/1ps
module ser_cfg_chk
  import ser_cfg_pkg::*;
#(
  parameter int PULSE_LEN = 2
) (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire logic [6:0]            strap_address,
  input wire logic                  address_strap_pin,
  input wire ser_cfg_pkg::reg_req_t req,
  input wire ser_cfg_pkg::cfg_out_t cfg,
  input wire logic [7:0]            rdata,
  input wire logic                  rdata_valid,
  input wire logic                  rom_reload_cmd,
  input wire logic                  logic_reset_out,
  input wire logic                  strap_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  int  run_ff;
  wire cmd_wr = req.wr && req.addr == ADDR_RST;
  // Length of the running reload pulse, so its width can be checked against PULSE_LEN.
  always_ff @(posedge sys_clk) run_ff <= (rst || !rom_reload_cmd) ? 0 : run_ff + 1;
  property p_rd; rdata_valid == $past(req.rd); endproperty
  a_rd: assert property (p_rd) else $error("read answer misplaced");
  property p_rl; cmd_wr && req.wdata[RELOAD_BIT] && !rom_reload_cmd |-> ##[1:3] rom_reload_cmd;
  endproperty
  a_rl: assert property (p_rl) else $error("reload not launched");
  property p_len; $fell(rom_reload_cmd) |-> run_ff == PULSE_LEN; endproperty
  a_len: assert property (p_len) else $error("reload pulse length wrong");
  property p_dr; cmd_wr && req.wdata[1:0] != 2'h0 && !logic_reset_out |-> ##[1:3] logic_reset_out;
  endproperty
  a_dr: assert property (p_dr) else $error("digital reset not launched");
  property p_def; $fell(rst) |-> ##[0:2] cfg.lane_sel == LANE_RST && cfg.crc_tx_enable; endproperty
  a_def: assert property (p_def) else $error("lane or crc default wrong");
  property p_st; $rose(strap_done) |-> ##[0:2] cfg.own_target_address == strap_address &&
    cfg.i2c_level_sel == address_strap_pin; endproperty
  a_st: assert property (p_st) else $error("strap value not taken");
  property p_hold; !req.rd |=> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_gen; req.wr && req.addr == ADDR_GEN |-> ##2
    cfg.lane_sel == $past(req.wdata[5:4], 2) &&
    cfg.clock_lane_continuous_sel == $past(req.wdata[6], 2) &&
    cfg.crc_tx_enable == $past(req.wdata[1], 2) && cfg.i2c_level_sel == $past(req.wdata[0], 2);
  endproperty
  a_gen: assert property (p_gen) else $error("config write not applied");
endmodule : ser_cfg_chk
bind ser_global_cfg ser_cfg_chk #(.PULSE_LEN(PULSE_LEN)) u_chk (.*);

// ==== dv/cfg_host.sv ====
// Purpose: Back-channel host issuing single-byte register requests.
// Assumes: Requests start just after a rising edge.
// Notes:   Read and write never share a cycle.
`timescale 1ns/1ps
module cfg_host
  import ser_cfg_pkg::*;
(
  input  wire logic             sys_clk,
  output ser_cfg_pkg::reg_req_t req,
  input  wire logic [7:0]       rdata,
  input  wire logic             rdata_valid
);
  initial req = '0;
  // Level writes are allowed here since this host sits behind the back channel.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
    @(posedge sys_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) req <= '0;
    #1 v = rdata;
    ok = rdata_valid;
  endtask : rd
endmodule : cfg_host

// ==== dv/tb.sv ====
// Purpose: Register-level tests of the global configuration block.
// Assumes: Straps held stable from time zero.
// Notes:   Waits after commands cover the pulse length.
`timescale 1ns/1ps
module tb;
  import ser_cfg_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [6:0] strap_address = 7'h5a;
  logic       address_strap_pin = 1'b1;
  reg_req_t   req;
  cfg_out_t   cfg;
  logic [7:0] rdata;
  logic       rdata_valid, rom_reload_cmd, logic_reset_out, strap_done;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  logic [7:0] gen_val [3] = '{8'h33, 8'h11, 8'h40};
  ser_global_cfg dut (.*);
  cfg_host host (.*);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %0t: saw 0x%h, expected 0x%h", $time, s, e);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    logic       ok;
    host.rd(a, v, ok);
    chk({7'h00, ok}, 8'h01);
    chk(v, e);
  endtask : rd_chk
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rd_chk(ADDR_ID, 8'hb4);
    rd_chk(ADDR_RST, 8'h00);
    rd_chk(ADDR_GEN, 8'h33);
    host.wr(ADDR_ID, 8'haa);
    rd_chk(ADDR_ID, 8'hb4);
    host.wr(ADDR_ID, 8'h01);
    host.wr(ADDR_ID, 8'h55);
    rd_chk(ADDR_ID, 8'h55);
    chk({1'b0, cfg.own_target_address}, 8'h2a);
    foreach (gen_val[i]) begin
      host.wr(ADDR_GEN, gen_val[i]);
      rd_chk(ADDR_GEN, gen_val[i]);
    end
    host.wr(ADDR_RST, 8'h04);
    repeat (PULSE_CYC + 3) @(posedge sys_clk);
    rd_chk(ADDR_RST, 8'h00);
    host.wr(ADDR_RST, 8'h01);
    repeat (PULSE_CYC + 3) @(posedge sys_clk);
    rd_chk(ADDR_GEN, 8'h40);
    rd_chk(ADDR_ID, 8'h55);
    host.wr(ADDR_RST, 8'h02);
    repeat (PULSE_CYC + 3) @(posedge sys_clk);
    rd_chk(ADDR_ID, 8'hb4);
    rd_chk(ADDR_GEN, 8'h33);
    rd_chk(8'h07, 8'h00);
    end_sim();
  end
endmodule : tb
